// *** include/mau_pkg.sv ***
// Shared constants, types and reset state of the multidrop autobaud UART port
`default_nettype none
package mau_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CW           = 20;
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned MIN_BAUD_BPS = 10_000;
  localparam int unsigned MAX_BAUD_BPS = 1_000_000;
  localparam int unsigned MIN_BIT_CYC  = CLK_HZ / MAX_BAUD_BPS;
  localparam int unsigned MAX_BIT_CYC  = CLK_HZ / MIN_BAUD_BPS;
  localparam logic [CW-1:0] BIT_FLOOR_CYC  = CW'(MIN_BIT_CYC - MIN_BIT_CYC / 4);
  localparam logic [CW-1:0] SYNC_MAX_DEF   = CW'(MAX_BIT_CYC * 10);
  localparam logic [CW-1:0] DISCARD_IDLE_DEF = CW'(MAX_BIT_CYC * 12);
  localparam int unsigned GAP_SHIFT    = 4;
  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [7:0] SYNC_BYTE  = 8'h79;
  localparam logic [7:0] ACK_BYTE   = 8'hC3;
  localparam logic [3:0] BIT_START  = 4'h0;
  localparam logic [3:0] BIT_D7     = 4'h8;
  localparam logic [3:0] BIT_PAR    = 4'h9;
  localparam logic [3:0] BIT_STOP   = 4'hA;
  localparam logic [3:0] TX_LAST    = 4'hB;
  localparam logic [2:0] FR_SYNC    = 3'h0;
  localparam logic [2:0] FR_ADDR    = 3'h1;
  localparam logic [2:0] FR_REG     = 3'h2;
  localparam logic [2:0] FR_DLO     = 3'h3;
  localparam logic [2:0] FR_WFINAL  = 3'h4;
  localparam logic [1:0] CAST_NODE  = 2'h0;
  localparam logic [1:0] CAST_GLOBAL = 2'h1;
  localparam logic [1:0] CAST_CLUSTER = 2'h2;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CTRL    = 3'h0;
  localparam logic [2:0] REG_STATUS  = 3'h1;
  localparam logic [2:0] REG_BAUD    = 3'h2;
  localparam logic [2:0] REG_WR_INFO = 3'h3;
  localparam logic [2:0] REG_RD_DATA = 3'h4;
  localparam logic [2:0] REG_RD_ADDR = 3'h5;
  localparam logic [2:0] REG_NODE    = 3'h6;
  localparam int unsigned ST_SYNC_ERR  = 0;
  localparam int unsigned ST_PAR_ERR   = 1;
  localparam int unsigned ST_STOP_ERR  = 2;
  localparam int unsigned ST_START_ERR = 3;
  localparam int unsigned ST_CRC_ERR   = 4;
  localparam int unsigned ST_WR_DONE   = 5;
  localparam int unsigned ST_RD_DONE   = 6;
  localparam int unsigned ST_RX_BUSY   = 8;
  localparam int unsigned ST_TX_BUSY   = 9;
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RX_IDLE    = 3'b000,
    RX_SYNC    = 3'b001,
    RX_GAP     = 3'b010,
    RX_FRAME   = 3'b011,
    RX_DISCARD = 3'b100
  } mau_rx_state_type;
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_BUSY = 1'b1
  } mau_tx_state_type;
  typedef struct packed {
    logic             rx_prev;
    mau_rx_state_type rx_st;
    logic [CW-1:0]    frame_cnt;
    logic [CW-1:0]    lvl_cnt;
    logic [CW-1:0]    tmr;
    logic [CW-1:0]    bit_cyc;
    logic [1:0]       edge_n;
    logic             sync_ok;
    logic [3:0]       bitn;
    logic [7:0]       sh;
    logic             fe_start;
    logic             fe_par;
    logic [2:0]       fidx;
    logic             is_rd;
    logic             match;
    logic [1:0]       cast;
    logic [2:0]       crc;
    logic             pkt_err;
    logic [7:0]       reg_addr;
    logic [7:0]       dlo;
    mau_tx_state_type tx_st;
    logic [CW-1:0]    tx_bit;
    logic [CW-1:0]    tx_tmr;
    logic [3:0]       tx_bitn;
    logic [11:0]      tx_sh;
    logic [1:0]       tx_left;
    logic [7:0]       tx_b1;
    logic [7:0]       tx_b2;
    logic             tx_oe;
    logic             tx_lvl;
    logic             strap_done;
    logic [3:0]       node_id;
    logic [5:0]       cluster;
    logic [6:0]       status;
    logic [7:0]       wr_addr;
    logic [12:0]      wr_data;
    logic [1:0]       wr_cast;
    logic [12:0]      rd_data;
    logic [7:0]       rd_addr;
    logic             wait_q;
    logic [31:0]      rdata;
  } mau_state_type;
  localparam mau_state_type RST_STATE = '{
    rx_prev: 1'b1, rx_st: RX_IDLE, tx_st: TX_IDLE, wait_q: 1'b1, default: '0};
endpackage : mau_pkg
`default_nettype wire

// *** hdl/mau_port.sv ***
// Autobaud receive, address match, check code and open-drain response of the UART port
//
// What this block does
// - Measure each packet's bit rate, 10k to 1000k
// - Answer at the rate just measured
// - Tx is open drain, only pulls low
// - Accept own, general call or cluster identity
// - Frame: start, eight data, even parity, stop
// - Sampling failure: no acknowledge, error flags set
// - Sync start edge starts the frame counter
// - Three level intervals compared to half count
// - All pass: bit period is count over eight
// - Responses open with acknowledge byte C3
// - Address: broadcast flag, six-bit identity, read flag
// - Write: five frames, final holds check code
// - Read: four frames; answer ack, low, final
// - Check code x3+x+1 from zero, LSB first
`timescale 1ns/100ps
`default_nettype none
module mau_port
  import mau_pkg::*;
#(
  parameter logic [CW-1:0] SYNC_MAX_CYCLES     = SYNC_MAX_DEF,
  parameter logic [CW-1:0] DISCARD_IDLE_CYCLES = DISCARD_IDLE_DEF
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [3:0]  i_address_strap_pin,
  input  wire logic        i_rx,
  input  wire logic        i_tx_in,
  output logic             o_tx_out,
  output logic             o_tx_oe
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] crc_step(input logic [2:0] c, input logic [7:0] d,
                                          input int unsigned n);
    logic [2:0] r;
    logic       fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (i < n) begin
        fb = d[i] ^ r[2];
        r  = {r[1], r[0] ^ fb, fb};
      end
    end
    return r;
  endfunction : crc_step

  function automatic logic near_half(input logic [CW-1:0] lvl, input logic [CW-1:0] frm);
    logic [CW-1:0] h;
    logic [CW-1:0] df;
    h  = frm >> 1;
    df = (lvl > h) ? (lvl - h) : (h - lvl);
    return df <= (frm >> 3);
  endfunction : near_half

  function automatic logic [11:0] tx_frame(input logic [7:0] b);
    return {2'b11, ^b, b, 1'b0};
  endfunction : tx_frame

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mau_state_type q;
  mau_state_type d;
  logic          rx_fall;
  logic          rx_edge;
  logic          tx_go;
  logic          sync_pass;
  logic          sync_fail;
  logic          pkt_bad;
  logic [31:0]   wmask;
  logic [31:0]   rd_mux;
  logic [7:0]    byte_in;
  logic          err_now;
  logic [2:0]    crc_fin;
  logic [2:0]    crc_rsp;
  logic          unused_tx_in;

  assign unused_tx_in = i_tx_in;

  always_comb begin
    d         = q;
    tx_go     = 1'b0;
    sync_pass = 1'b0;
    sync_fail = 1'b0;
    pkt_bad   = 1'b0;
    rx_fall   = q.rx_prev & ~i_rx;
    rx_edge   = q.rx_prev ^ i_rx;
    byte_in   = q.sh;
    err_now   = q.pkt_err | q.fe_start | q.fe_par | ~i_rx;
    crc_fin   = crc_step(q.crc, q.sh, 5);
    crc_rsp   = crc_step(crc_step(3'h0, q.rd_data[7:0], 8), {3'h0, q.rd_data[12:8]}, 5);
    wmask     = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                 {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    rd_mux    = '0;
    d.rx_prev = i_rx;
    if (!q.strap_done) begin
      d.node_id    = i_address_strap_pin;
      d.strap_done = 1'b1;
    end
    // ----------------------------------------------------------------
    // Register bus: one wait cycle, then the access is taken
    // ----------------------------------------------------------------
    case (i_avs_address[4:2])
      REG_CTRL:    rd_mux[5:0] = q.cluster;
      REG_STATUS: begin
        rd_mux[6:0]        = q.status;
        rd_mux[ST_RX_BUSY] = (q.rx_st != RX_IDLE);
        rd_mux[ST_TX_BUSY] = (q.tx_st == TX_BUSY);
      end
      REG_BAUD:    rd_mux[CW-1:0] = q.bit_cyc;
      REG_WR_INFO: rd_mux[25:0] = {q.wr_cast, 3'h0, q.wr_data, q.wr_addr};
      REG_RD_DATA: rd_mux[12:0] = q.rd_data;
      REG_RD_ADDR: rd_mux[7:0] = q.rd_addr;
      REG_NODE:    rd_mux[3:0] = q.node_id;
      default:     rd_mux = '0;
    endcase
    if (q.wait_q) begin
      if (i_avs_read || i_avs_write) begin
        d.wait_q = 1'b0;
        d.rdata  = i_avs_read ? rd_mux : 32'h0000_0000;
      end
    end else begin
      d.wait_q = 1'b1;
      if (i_avs_write) begin
        case (i_avs_address[4:2])
          REG_CTRL:    d.cluster = (q.cluster & ~wmask[5:0]) | (i_avs_writedata[5:0] & wmask[5:0]);
          REG_STATUS:  d.status = q.status & ~(i_avs_writedata[6:0] & wmask[6:0]);
          REG_RD_DATA: d.rd_data = (q.rd_data & ~wmask[12:0])
                                   | (i_avs_writedata[12:0] & wmask[12:0]);
          default: ;
        endcase
      end
    end
    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    if (q.tx_st == TX_BUSY) begin
      if (q.tx_tmr != '0) begin
        d.tx_tmr = q.tx_tmr - 1'b1;
      end else begin
        d.tx_tmr = q.tx_bit - 1'b1;
        if (q.tx_bitn == TX_LAST) begin
          if (q.tx_left != 2'h0) begin
            d.tx_sh   = tx_frame(q.tx_b1);
            d.tx_b1   = q.tx_b2;
            d.tx_left = q.tx_left - 1'b1;
            d.tx_bitn = 4'h0;
            d.tx_oe   = 1'b1;
          end else begin
            d.tx_st = TX_IDLE;
            d.tx_oe = 1'b0;
          end
        end else begin
          d.tx_sh   = {1'b1, q.tx_sh[11:1]};
          d.tx_bitn = q.tx_bitn + 1'b1;
          d.tx_oe   = ~q.tx_sh[1];
        end
      end
    end
    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    case (q.rx_st)
      RX_IDLE: begin
        if (rx_fall) begin
          d.rx_st     = RX_SYNC;
          d.frame_cnt = '0;
          d.lvl_cnt   = '0;
          d.edge_n    = 2'h0;
          d.sync_ok   = 1'b1;
        end
      end
      RX_SYNC: begin
        d.frame_cnt = q.frame_cnt + 1'b1;
        d.lvl_cnt   = q.lvl_cnt + 1'b1;
        if (q.frame_cnt >= SYNC_MAX_CYCLES) begin
          sync_fail = 1'b1;
        end else if (rx_edge) begin
          d.lvl_cnt = '0;
          d.edge_n  = q.edge_n + 1'b1;
          if (q.edge_n != 2'h0 && !near_half(q.lvl_cnt, q.frame_cnt)) begin
            d.sync_ok = 1'b0;
          end
          if (q.edge_n == 2'h3) begin
            // Count includes this edge's clock, so it spans eight whole bits
            if (d.sync_ok && (d.frame_cnt >> 3) >= BIT_FLOOR_CYC) begin
              sync_pass = 1'b1;
              d.bit_cyc = d.frame_cnt >> 3;
              d.rx_st   = RX_FRAME;
              d.bitn    = BIT_D7;
              d.tmr     = (d.frame_cnt >> 3) >> 1;
              // Seven bits seen; D7 shifts in on top of them
              d.sh      = SYNC_BYTE << 1;
              d.fe_start = 1'b0;
              d.fe_par  = 1'b0;
              d.fidx    = FR_SYNC;
              d.crc     = 3'h0;
              d.pkt_err = 1'b0;
              d.match   = 1'b0;
            end else begin
              sync_fail = 1'b1;
            end
          end
        end
      end
      RX_GAP: begin
        d.lvl_cnt = q.lvl_cnt + 1'b1;
        if (rx_fall) begin
          d.rx_st    = RX_FRAME;
          d.tmr      = q.bit_cyc >> 1;
          d.bitn     = BIT_START;
          d.fe_start = 1'b0;
          d.fe_par   = 1'b0;
        end else if ({4'h0, q.lvl_cnt} >= {q.bit_cyc, 4'h0}) begin
          d.rx_st = RX_IDLE;
        end
      end
      RX_FRAME: begin
        if (q.tmr != '0) begin
          d.tmr = q.tmr - 1'b1;
        end else begin
          d.tmr  = q.bit_cyc - 1'b1;
          d.bitn = q.bitn + 1'b1;
          if (q.bitn == BIT_START) begin
            d.fe_start = i_rx;
          end else if (q.bitn <= BIT_D7) begin
            d.sh = {i_rx, q.sh[7:1]};
          end else if (q.bitn == BIT_PAR) begin
            d.fe_par = (i_rx != ^q.sh);
          end else if (q.fidx == FR_SYNC) begin
            if (q.fe_par || !i_rx) begin
              sync_fail = 1'b1;
            end else begin
              d.rx_st   = RX_GAP;
              d.lvl_cnt = '0;
              d.fidx    = FR_ADDR;
            end
          end else begin
            if (q.fe_par)   d.status[ST_PAR_ERR] = 1'b1;
            if (!i_rx)      d.status[ST_STOP_ERR] = 1'b1;
            if (q.fe_start) d.status[ST_START_ERR] = 1'b1;
            d.pkt_err = err_now;
            d.rx_st   = RX_GAP;
            d.lvl_cnt = '0;
            d.fidx    = q.fidx + 1'b1;
            if (q.fidx == FR_ADDR) begin
              d.crc   = crc_step(q.crc, byte_in, 8);
              d.is_rd = byte_in[0];
              if (!byte_in[7] && byte_in[6:1] == {2'b00, q.node_id}) begin
                d.match = 1'b1;
                d.cast  = CAST_NODE;
              end else if (byte_in[7] && !byte_in[0] && byte_in[6:1] == 6'h00) begin
                d.match = 1'b1;
                d.cast  = CAST_GLOBAL;
              end else if (byte_in[7] && !byte_in[0] && byte_in[6:1] == q.cluster) begin
                d.match = 1'b1;
                d.cast  = CAST_CLUSTER;
              end
            end else if (q.fidx == FR_REG) begin
              d.crc      = crc_step(q.crc, byte_in, 8);
              d.reg_addr = byte_in;
            end else if (q.fidx == FR_DLO && !q.is_rd) begin
              d.crc = crc_step(q.crc, byte_in, 8);
              d.dlo = byte_in;
            end else begin
              d.rx_st = RX_IDLE;
              if (crc_fin != byte_in[7:5]) d.status[ST_CRC_ERR] = 1'b1;
              pkt_bad = err_now || (crc_fin != byte_in[7:5]);
              if (!pkt_bad && q.match) begin
                if (q.is_rd) begin
                  d.status[ST_RD_DONE] = 1'b1;
                  d.rd_addr = q.reg_addr;
                end else begin
                  d.status[ST_WR_DONE] = 1'b1;
                  d.wr_addr = q.reg_addr;
                  d.wr_data = {byte_in[4:0], q.dlo};
                  d.wr_cast = q.cast;
                end
                if (q.cast == CAST_NODE && q.tx_st == TX_IDLE) begin
                  tx_go     = 1'b1;
                  d.tx_st   = TX_BUSY;
                  d.tx_bit  = q.bit_cyc;
                  d.tx_tmr  = q.bit_cyc - 1'b1;
                  d.tx_bitn = 4'h0;
                  d.tx_sh   = tx_frame(ACK_BYTE);
                  d.tx_oe   = 1'b1;
                  d.tx_left = q.is_rd ? 2'h2 : 2'h0;
                  d.tx_b1   = q.rd_data[7:0];
                  d.tx_b2   = {crc_rsp, q.rd_data[12:8]};
                end
              end
            end
          end
        end
      end
      RX_DISCARD: begin
        d.lvl_cnt = i_rx ? (q.lvl_cnt + 1'b1) : '0;
        if (q.lvl_cnt >= DISCARD_IDLE_CYCLES) d.rx_st = RX_IDLE;
      end
      default: d.rx_st = RX_IDLE;
    endcase
    if (sync_fail) begin
      d.rx_st               = RX_DISCARD;
      d.lvl_cnt             = '0;
      d.status[ST_SYNC_ERR] = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) q <= RST_STATE;
    else          q <= d;
  end

  assign o_avs_readdata    = q.rdata;
  assign o_avs_waitrequest = q.wait_q;
  assign o_tx_out          = q.tx_lvl;
  assign o_tx_oe           = q.tx_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_tx_released;
    @(posedge i_mclk) disable iff (!i_rst_n) (q.tx_st == TX_IDLE) |-> !o_tx_oe;
  endproperty
  a_tx_released: assert property (p_tx_released) else $error("Tx driven while idle");

  property p_open_drain;
    @(posedge i_mclk) disable iff (!i_rst_n) tx_go |=> (o_tx_oe && !o_tx_out)[*2];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Start bit not pulled low");

  property p_sync_start;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (q.rx_st == RX_IDLE && rx_fall) |=> (q.rx_st == RX_SYNC && q.frame_cnt == '0);
  endproperty
  a_sync_start: assert property (p_sync_start) else $error("Frame counter not started");

  property p_level_reset;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (q.rx_st == RX_SYNC && rx_edge && !sync_fail && q.edge_n != 2'h3) |=> q.lvl_cnt == '0;
  endproperty
  a_level_reset: assert property (p_level_reset) else $error("Level counter not reset");

  property p_baud;
    @(posedge i_mclk) disable iff (!i_rst_n)
      sync_pass |=> (q.bit_cyc == (q.frame_cnt >> 3) && q.rx_st == RX_FRAME);
  endproperty
  a_baud: assert property (p_baud) else $error("Bit period not count over eight");

  property p_tx_rate;
    @(posedge i_mclk) disable iff (!i_rst_n)
      tx_go |=> (q.tx_bit == q.bit_cyc && q.tx_tmr == q.bit_cyc - 1'b1);
  endproperty
  a_tx_rate: assert property (p_tx_rate) else $error("Response rate differs");

  property p_ack_first;
    @(posedge i_mclk) disable iff (!i_rst_n)
      tx_go |=> (q.tx_sh[8:1] == ACK_BYTE && q.tx_sh[9] == ^ACK_BYTE);
  endproperty
  a_ack_first: assert property (p_ack_first) else $error("Response not opened by ack");

  property p_no_ack_on_err;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (pkt_bad && q.tx_st == TX_IDLE) |=> (q.tx_st == TX_IDLE && !o_tx_oe)[*2];
  endproperty
  a_no_ack_on_err: assert property (p_no_ack_on_err) else $error("Ack after bad packet");

  property p_sync_reject;
    @(posedge i_mclk) disable iff (!i_rst_n)
      sync_fail |=> (q.rx_st == RX_DISCARD && q.status[ST_SYNC_ERR]);
  endproperty
  a_sync_reject: assert property (p_sync_reject) else $error("Bad sync not dropped");

  property p_bus_wait;
    @(posedge i_mclk) disable iff (!i_rst_n)
      ((i_avs_read || i_avs_write) && q.wait_q) |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("Bus answer not one cycle");
endmodule : mau_port
`default_nettype wire

// *** verif/mau_host.sv ***
// Host controller model: sends Rx frames and decodes the shared Tx wire
`timescale 1ns/100ps
`default_nettype none
module mau_host (
  input  wire logic i_mclk,
  input  wire logic i_tx_line,
  output logic      o_rx
);
  int         bp = 250;
  logic [9:0] got[$];
  initial o_rx = 1'b1;
  // ------
  // Drive
  // ------
  // One frame, two stop bits, no gap before the next start
  task automatic send(input logic [7:0] b, input logic flip);
    logic [11:0] f;
    f = {2'b11, ^b ^ flip, b, 1'b0};
    for (int i = 0; i < 12; i++) begin
      o_rx <= f[i];
      repeat (bp) @(posedge i_mclk);
    end
  endtask : send
  // ------
  // Listen
  // ------
  // Samples mid-bit at the host's own rate: data, parity, stop
  initial forever begin
    logic [9:0] d;
    @(negedge i_tx_line);
    repeat (bp / 2) @(posedge i_mclk);
    for (int i = 0; i < 10; i++) begin
      repeat (bp) @(posedge i_mclk);
      d[i] = i_tx_line;
    end
    got.push_back(d);
  end
endmodule : mau_host
`default_nettype wire

// *** verif/mau_port_test.sv ***
// Self-checking bench of the UART port: register bus, packets and answers
`timescale 1ns/100ps
`default_nettype none
module mau_port_test import mau_pkg::*;;
  logic        i_mclk  = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [4:0]  adr     = '0;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wd      = '0;
  logic [31:0] rdat;
  logic        wreq;
  logic [3:0]  strap;
  logic        rx;
  logic        tx_out;
  logic        tx_oe;
  wire logic   tx_line = ~(tx_oe & ~tx_out);
  int          fail_count = 0;
  int          tests_run  = 0;
  int          seed       = 32676;
  int          bp;
  logic [31:0] v;
  logic [12:0] rdv;
  logic [5:0]  cl;
  initial forever #2 i_mclk = ~i_mclk;
  mau_port #(.SYNC_MAX_CYCLES(20'h04E20), .DISCARD_IDLE_CYCLES(20'h007D0)) u_dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_address_strap_pin(strap),
    .i_rx(rx), .i_tx_in(tx_line), .o_tx_out(tx_out), .o_tx_oe(tx_oe));
  mau_host u_host (.i_mclk(i_mclk), .i_tx_line(tx_line), .o_rx(rx));
  // ------
  // Helpers
  // ------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    rd  <= ~w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    do @(posedge i_mclk); while (wreq !== 1'b0);
    v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc
  function automatic logic [2:0] crc(input logic [2:0] c, input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
      c = {c[1], c[0] ^ b[i] ^ c[2], b[i] ^ c[2]};
    return c;
  endfunction : crc
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // One packet, then its answer, status flags and captured fields
  task automatic pkt(input logic [7:0] ad, input logic [12:0] dat, input logic [7:0] sy,
                     input logic [2:0] cx, input logic fp, input int nr, input logic [6:0] st);
    logic [7:0] rg;
    logic [2:0] c;
    logic [1:0] cs;
    logic [7:0] e[3];
    rg = 8'($random(seed));
    c  = crc(crc(3'h0, ad, 8), rg, 8);
    if (!ad[0]) c = crc(c, dat[7:0], 8);
    c  = crc(c, {3'h0, dat[12:8]}, 5) ^ cx;
    cs = ad[7] ? ((ad[6:1] == 6'h00) ? CAST_GLOBAL : CAST_CLUSTER) : CAST_NODE;
    u_host.send(sy, 1'b0);
    if (sy == SYNC_BYTE) begin
      u_host.send(ad, 1'b0);
      u_host.send(rg, 1'b0);
      if (!ad[0]) u_host.send(dat[7:0], 1'b0);
      u_host.send({c, dat[12:8]}, fp);
    end
    repeat ((12 * nr + 2) * bp + 2500) @(posedge i_mclk);
    c = crc(crc(3'h0, rdv[7:0], 8), {3'h0, rdv[12:8]}, 5);
    e = '{ACK_BYTE, rdv[7:0], {c, rdv[12:8]}};
    chk("answer frames", 32'(nr), 32'(u_host.got.size()));
    foreach (u_host.got[i])
      if (i < 3) chk("tx frame", 32'({1'b1, ^e[i], e[i]}), 32'(u_host.got[i]));
    u_host.got.delete();
    acc(1'b0, 5'h04, 32'h0);
    chk("status", 32'(st), v & 32'h7F);
    acc(1'b1, 5'h04, 32'h7F);
    if (st[5]) begin
      acc(1'b0, 5'h0C, 32'h0);
      chk("write info", {6'h00, cs, 3'h0, dat, rg}, v);
    end
    if (st[6]) begin
      acc(1'b0, 5'h14, 32'h0);
      chk("read address", 32'(rg), v);
    end
  endtask : pkt
  // ------
  // Sequence
  // ------
  always @(posedge i_mclk)
    if (tx_oe === 1'b1 && tx_out !== 1'b0) begin
      fail_count++;
      $display("wrong value tx drive expected 0 seen %b", tx_out);
    end
  initial begin
    repeat (200000) @(posedge i_mclk);
    fail_count++;
    give_verdict();
  end
  initial begin
    strap = 4'($random(seed));
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    acc(1'b0, 5'h18, 32'h0);
    chk("node identity", 32'(strap), v);
    acc(1'b0, 5'h00, 32'h0);
    chk("cluster reset", 32'h0, v);
    acc(1'b0, 5'h1C, 32'h0);
    chk("unmapped", 32'h0, v);
    cl  = 6'($random(seed)) | 6'h01;
    rdv = 13'($random(seed));
    acc(1'b1, 5'h00, 32'(cl));
    acc(1'b1, 5'h10, 32'(rdv));
    for (int k = 0; k < 8; k++) begin
      bp = 250 + ($random(seed) & 31);
      u_host.bp = bp;
      v = 32'($random(seed));
      case (k)
        0: pkt({3'h0, strap, 1'b0}, v[12:0], SYNC_BYTE, 3'h0, 1'b0, 1, 7'h20);
        1: pkt({3'h0, strap, 1'b1}, 13'h0, SYNC_BYTE, 3'h0, 1'b0, 3, 7'h40);
        2: pkt(8'h80, v[12:0], SYNC_BYTE, 3'h0, 1'b0, 0, 7'h20);
        3: pkt({1'b1, cl, 1'b0}, v[12:0], SYNC_BYTE, 3'h0, 1'b0, 0, 7'h20);
        4: pkt({3'h0, strap + 4'h1, 1'b0}, v[12:0], SYNC_BYTE, 3'h0, 1'b0, 0, 7'h00);
        5: pkt({3'h0, strap, 1'b0}, v[12:0], SYNC_BYTE, 3'h5, 1'b0, 0, 7'h10);
        6: pkt({3'h0, strap, 1'b0}, v[12:0], SYNC_BYTE, 3'h0, 1'b1, 0, 7'h02);
        default: pkt(8'h00, 13'h0, 8'h55, 3'h0, 1'b0, 0, 7'h01);
      endcase
      if (k < 2) begin
        acc(1'b0, 5'h08, 32'h0);
        chk("bit period", 32'(bp), v);
      end
    end
    give_verdict();
  end
endmodule : mau_port_test
`default_nettype wire
